// *** verification/sensor_serial_responder_tb_top.sv ***
// Purpose: Self-checking bench for the sensor serial responder
// Assumes: BIT_CYCLES 8 and RAISE_CYCLES 20 keep the run short
// Notes:   Inputs move on falling edges; the logger model frames all characters
module sensor_serial_responder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ssr_pkg::*;
  logic       clk_in, arst_n_in, line_in, line_out, line_oe_out, meas_start_out, meas_done_in;
  logic       addr_wr_out, drv_oe, drv;
  logic [7:0] addr_nv_in, addr_nv_out;
  ssr_meas_t  meas_in;
  int         err_count, samples_checked;
  int         starts, writes;
  // Strobe counts, taken off the falling edge after launch
  always @(negedge clk_in) begin
    starts += meas_start_out;
    writes += addr_wr_out;
  end
  // Undriven line is pulled low
  assign line_in = line_oe_out ? line_out : (drv_oe ? drv : 1'b0);
  sensor_serial_responder #(.BIT_CYCLES(8), .RAISE_CYCLES(20)) u_dut (.clk_in, .arst_n_in, .line_in, .line_out,
    .line_oe_out, .meas_start_out, .meas_done_in, .meas_in, .addr_nv_in, .addr_nv_out, .addr_wr_out);
  ssr_logger_model #(.BIT(8)) u_logger (.clk_in, .wire_in(line_in), .drv_oe_out(drv_oe), .drv_out(drv));
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  task automatic check(input logic [9:0] seen, input logic [9:0] want);
    samples_checked++;
    if (seen !== want) begin
      err_count++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic rx(input logic cmd, input string s);
    logic [9:0] f;
    for (int i = 0; i < s.len(); i++) begin
      u_logger.recv(cmd, f);
      check(f, u_logger.frame(cmd, s[i]));
      if (f === 10'h3ff) complete_run();
    end
  endtask
  task automatic tx(input string s);
    repeat (8) @(negedge clk_in);
    for (int i = 0; i < s.len(); i++) u_logger.send(s[i]);
  endtask
  task automatic quiet();
    repeat (8) @(negedge clk_in);
    repeat (60) @(negedge clk_in) check(10'(line_oe_out), 10'h000);
  endtask
  task automatic pulse_done(input logic [6:0] d, input logic [7:0] t, input logic [10:0] r);
    meas_in = '{d, t, r};
    meas_done_in = 1'b1;
    @(negedge clk_in) meas_done_in = 1'b0;
  endtask
  task automatic do_reset(input logic [7:0] a);
    arst_n_in = 1'b0;
    addr_nv_in = a;
    repeat (8) @(negedge clk_in);
    check(10'(addr_nv_out), 10'h030);
    arst_n_in = 1'b1;
    repeat (60) @(negedge clk_in);
  endtask
  task automatic t_burst();
    string      s;
    int         sum;
    logic [9:0] f;
    s = "\t150 600\rA";
    sum = 0;
    for (int i = 0; i < s.len(); i++) sum += s[i];
    do_reset(8'h30);
    // raw 600 goes out unscaled as 600 in the burst; the 20 C is fed in separately as temp_c
    pulse_done(7'd3, 8'h14, 11'd600);
    rx(1'b0, s);
    u_logger.recv(1'b0, f);
    check(f, u_logger.frame(1'b0, 8'(sum % 64 + 32)));
    if (f === 10'h3ff) complete_run();
    quiet();
    $display("burst test done");
  endtask
  task automatic t_cmds();
    tx("?!");
    rx(1'b1, "0\r\n");
    tx("1!");
    quiet();
    tx("?A5!");
    quiet();
    tx("0A5!");
    rx(1'b1, "5\r\n");
    check(10'(addr_nv_out), 10'h035);
    check(10'(writes), 10'd1);
    tx("0!");
    quiet();
    tx("?M!");
    rx(1'b1, "50012\r\n");
    check(10'(starts), 10'd2);
    pulse_done(7'd2, 8'hfb, 11'd0);
    rx(1'b1, "5\r\n");
    // data asked only after the service request
    tx("5D0!");
    rx(1'b1, "5+2-5\r\n");
    $display("command test done");
  endtask
  task automatic t_noburst();
    do_reset(8'h35);
    quiet();
    tx("?!");
    rx(1'b1, "5\r\n");
    tx("5!");
    rx(1'b1, "5\r\n");
    $display("stored address test done");
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    {err_count, samples_checked} = '0;
    {meas_done_in, meas_in, arst_n_in} = '0;
    addr_nv_in = 8'h30;
    t_burst();
    t_cmds();
    t_noburst();
    complete_run();
  end
endmodule // sensor_serial_responder_tb_top
bind sensor_serial_responder ssr_resp_sva #(.RAISE_CYCLES(RAISE_CYCLES)) u_sva (.clk_in, .arst_n_in, .line_out,
  .line_oe_out, .meas_start_out, .addr_nv_out, .addr_wr_out);

// *** verification/ssr_logger_model.sv ***
// Purpose: Logger side of the shared data line
// Assumes: Open line reads low; a single sensor is attached
// Notes:   Receive returns raw wire levels of one frame, all ones on timeout
module ssr_logger_model #(
  parameter int BIT = 8
) (
  // Clock and line
  input  wire logic clk_in,
  input  wire logic wire_in,
  output logic      drv_oe_out,
  output logic      drv_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {drv_oe_out, drv_out} = 2'b00;
  function automatic logic [9:0] frame(input logic cmd, input logic [7:0] c);
    if (cmd) return {1'b0, ~(^c[6:0]), ~c[6:0], 1'b1};
    return {1'b1, c, 1'b0};
  endfunction
  task automatic send(input logic [7:0] c);
    logic [9:0] f;
    f = frame(1'b1, c);
    repeat (BIT / 2) @(negedge clk_in);
    // Stop level equals the pull, so the line is let go after parity
    for (int i = 0; i < 9; i++) begin
      drv_out = f[i];
      drv_oe_out = 1'b1;
      repeat (BIT) @(negedge clk_in);
    end
    drv_oe_out = 1'b0;
    repeat (BIT / 2) @(negedge clk_in);
  endtask
  task automatic recv(input logic cmd, output logic [9:0] f);
    int n;
    n = 0;
    f = 10'h3ff;
    // framing begins at a start level only
    while (wire_in !== cmd && n < 20000) @(negedge clk_in) n++;
    if (n == 20000) return;
    repeat (BIT / 2) @(negedge clk_in);
    for (int i = 0; i < 10; i++) begin
      f[i] = wire_in;
      if (i < 9) repeat (BIT) @(negedge clk_in);
    end
  endtask
endmodule // ssr_logger_model

// *** verification/ssr_resp_sva.sv ***
// Purpose: Port checks for the sensor serial responder
// Assumes: BIT_CYCLES of 8, so every bit holds eight cycles
// Notes:   A counter gives the cycles since reset release
module ssr_resp_sva #(
  parameter int unsigned RAISE_CYCLES = 20
) (
  // Watched ports
  input wire logic       clk_in,
  input wire logic       arst_n_in,
  input wire logic       line_out,
  input wire logic       line_oe_out,
  input wire logic       meas_start_out,
  input wire logic [7:0] addr_nv_out,
  input wire logic       addr_wr_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt_q;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // Saturates, so a long run never wraps into the start-up checks
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) cnt_q <= 16'h0000;
    else if (cnt_q != 16'hffff) cnt_q <= cnt_q + 16'h0001;
  end
  function automatic logic alnum(input logic [7:0] a);
    return a inside {[8'h30:8'h39], [8'h41:8'h5a], [8'h61:8'h7a]};
  endfunction
  property p_wr_pulse; addr_wr_out |=> !addr_wr_out; endproperty
  property p_addr_ok; alnum(addr_nv_out); endproperty
  property p_wr_src; (cnt_q > 16'h0010 && $changed(addr_nv_out)) |-> ##[0:1] (addr_wr_out || $past(addr_wr_out)); endproperty
  property p_start_pulse; meas_start_out |=> !meas_start_out; endproperty
  property p_raise; cnt_q == 16'(RAISE_CYCLES + 12) |-> (!line_oe_out || line_out); endproperty
  property p_no_burst; (cnt_q == 16'(RAISE_CYCLES + 12) && addr_nv_out != 8'h30) |-> !line_oe_out; endproperty
  property p_start_hi; (cnt_q > 16'(RAISE_CYCLES + 12) && $rose(line_oe_out)) |=> line_out; endproperty
  property p_bit; ($changed(line_out) && line_oe_out) |=> (!line_oe_out || $stable(line_out)) [*7]; endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
  a_addr_ok: assert property (p_addr_ok) else $error("address not alphanumeric");
  a_wr_src: assert property (p_wr_src) else $error("address moved without write");
  a_start_pulse: assert property (p_start_pulse) else $error("start strobe too long");
  a_raise: assert property (p_raise) else $error("line not raised in time");
  a_no_burst: assert property (p_no_burst) else $error("burst with nonzero address");
  a_start_hi: assert property (p_start_hi) else $error("command start bit not high");
  a_bit: assert property (p_bit) else $error("bit shorter than eight cycles");
  c_wr: cover property (addr_wr_out);
  c_meas: cover property (meas_start_out);
  c_tx: cover property ($rose(line_oe_out) && line_out);
endmodule // ssr_resp_sva

// *** verilog/sensor_serial_responder.sv ***
// Purpose: Sensor side of a shared data line: power-up burst at the factory address, then command mode
// Assumes: Front end measures on meas_start_out and pulses meas_done_in after
// Notes:   Address lives in nonvolatile storage outside; read once after reset
module sensor_serial_responder #(
  parameter int unsigned BIT_CYCLES   = ssr_pkg::BIT_CYCLES_DFLT,
  parameter int unsigned RAISE_CYCLES = ssr_pkg::RAISE_CYCLES,
  // Arbitrary printable type code
  parameter logic [7:0]  SENSOR_TYPE  = 8'h41
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             arst_n_in,
  // Data line
  input  wire logic             line_in,
  output logic                  line_out,
  output logic                  line_oe_out,
  // Measurement front end
  output logic                  meas_start_out,
  input  wire logic             meas_done_in,
  input  wire ssr_pkg::ssr_meas_t meas_in,
  // Nonvolatile address store
  input  wire logic [7:0]       addr_nv_in,
  output logic [7:0]            addr_nv_out,
  output logic                  addr_wr_out
);
  import ssr_pkg::*;

  logic        rst_s1_q, rst_n;
  logic        line_s1_q, line_s2_q;
  ssr_pwr_t    pwr_q;
  logic [21:0] raise_cnt_q;
  logic [7:0]  addr_q;
  logic        meas_start_q, meas_busy_q, srq_pend_q;
  ssr_meas_t   meas_q;
  ssr_rx_t     rx_q;
  logic [15:0] rx_cnt_q;
  logic [3:0]  rx_bit_q;
  logic [8:0]  rx_sh_q;
  logic        rx_valid_q;
  logic [6:0]  rx_char_q;
  logic [7:0]  cbuf_q [4];
  logic [2:0]  ccnt_q;
  ssr_msg_t    msg_q, reply_q;
  logic [3:0]  idx_q;
  logic [5:0]  sum_q;
  logic        send_q;
  logic [7:0]  send_char_q;
  logic        tx_busy, tx_pin;
  logic        line_q, line_oe_q, addr_wr_q;
  logic [7:0]  cur_char;
  logic        cur_last, cur_skip, cur_sum;
  logic [15:0] perm_bcd, raw_perm_bcd, raw_temp_bcd, temp_bcd, time_bcd;
  logic [7:0]  temp_mag;
  logic        cmd_hit, is_wild, addr_ok, new_ok;

  function automatic logic [15:0] bin2bcd(input logic [12:0] bin);
    logic [15:0] b;
    b = 16'h0000;
    for (int i = 12; i >= 0; i--) begin
      for (int k = 0; k < 4; k++) begin
        if (b[4*k +: 4] > 4'h4) begin
          b[4*k +: 4] = b[4*k +: 4] + 4'h3;
        end
      end
      b = {b[14:0], bin[i]};
    end
    return b;
  endfunction

  function automatic logic [7:0] digit(input logic [3:0] d);
    return CH_ZERO | {4'h0, d};
  endfunction

  function automatic logic valid_addr(input logic [7:0] c);
    return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h5a) ||
           (c >= 8'h61 && c <= 8'h7a);
  endfunction

  // Reset release and pin synchroniser
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_s1_q  <= 1'b0;
      rst_n     <= 1'b0;
      line_s1_q <= 1'b0;
      line_s2_q <= 1'b0;
    end else begin
      rst_s1_q  <= 1'b1;
      rst_n     <= rst_s1_q;
      line_s1_q <= line_in;
      line_s2_q <= line_s1_q;
    end
  end

  // Power-up sequence
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pwr_q       <= PWR_STRAP;
      raise_cnt_q <= 22'h000000;
    end else begin
      unique case (pwr_q)
        PWR_STRAP: begin
          pwr_q <= (valid_addr(addr_nv_in) && addr_nv_in != ADDR_FACTORY) ? PWR_CMD : PWR_LOW;
        end
        PWR_LOW: begin
          raise_cnt_q <= raise_cnt_q + 22'h000001;
          if (raise_cnt_q == 22'(RAISE_CYCLES - 1)) begin
            pwr_q <= PWR_HIGH;
          end
        end
        PWR_HIGH: begin
          // Stay high until front end finishes
          if (meas_done_in) begin
            pwr_q <= PWR_BURST;
          end
        end
        PWR_BURST: begin
          if (msg_q == MSG_NONE && !send_q && !tx_busy) begin
            pwr_q <= PWR_CMD;
          end
        end
        PWR_CMD: pwr_q <= PWR_CMD;
      endcase
    end
  end

  // Address register and nonvolatile write
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      addr_q    <= ADDR_FACTORY;
      addr_wr_q <= 1'b0;
    end else begin
      addr_wr_q <= 1'b0;
      if (pwr_q == PWR_STRAP) begin
        addr_q <= valid_addr(addr_nv_in) ? addr_nv_in : ADDR_FACTORY;
      end else if (cmd_hit && ccnt_q == 3'd3 && cbuf_q[1] == CH_CMD_A && addr_ok && new_ok) begin
        addr_q    <= cbuf_q[2];
        addr_wr_q <= 1'b1;
      end
    end
  end

  function automatic logic is_meas_cmd();
    return ccnt_q == 3'd2 && cbuf_q[1] == CH_CMD_M && (addr_ok || is_wild);
  endfunction

  // Measurement handshake and result capture
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      meas_start_q <= 1'b0;
      meas_busy_q  <= 1'b0;
      srq_pend_q   <= 1'b0;
      meas_q       <= '0;
    end else begin
      meas_start_q <= (pwr_q == PWR_STRAP) || (cmd_hit && reply_q == MSG_NONE && is_meas_cmd());
      if (meas_done_in) begin
        meas_q <= meas_in;
      end
      if (cmd_hit && is_meas_cmd()) begin
        meas_busy_q <= 1'b1;
      end else if (meas_done_in) begin
        meas_busy_q <= 1'b0;
      end
      // Service request after a commanded measurement; set wins
      if (meas_done_in && meas_busy_q) begin
        srq_pend_q <= 1'b1;
      end else if (msg_q == MSG_NONE && reply_q == MSG_NONE && pwr_q == PWR_CMD && !tx_busy) begin
        srq_pend_q <= 1'b0;
      end
    end
  end

  // Command receiver: inverted 7E1, listens only while silent
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rx_q       <= RX_IDLE;
      rx_cnt_q   <= 16'h0000;
      rx_bit_q   <= 4'h0;
      rx_sh_q    <= 9'h000;
      rx_valid_q <= 1'b0;
      rx_char_q  <= 7'h00;
    end else begin
      rx_valid_q <= 1'b0;
      unique case (rx_q)
        RX_IDLE: begin
          if (pwr_q == PWR_CMD && msg_q == MSG_NONE && !tx_busy && line_s2_q) begin
            rx_q     <= RX_START;
            rx_cnt_q <= 16'(BIT_CYCLES / 2);
          end
        end
        RX_START: begin
          if (rx_cnt_q != 16'h0000) begin
            rx_cnt_q <= rx_cnt_q - 16'h0001;
          end else if (line_s2_q) begin
            rx_q     <= RX_BITS;
            rx_bit_q <= 4'h0;
            rx_cnt_q <= 16'(BIT_CYCLES - 1);
          end else begin
            rx_q <= RX_IDLE;
          end
        end
        RX_BITS: begin
          if (rx_cnt_q != 16'h0000) begin
            rx_cnt_q <= rx_cnt_q - 16'h0001;
          end else if (rx_bit_q == 4'h8) begin
            rx_q <= RX_IDLE;
            // Stop must be a mark and data plus parity even
            if (line_s2_q == 1'b0 && ^rx_sh_q[8:1] == 1'b0) begin
              rx_valid_q <= 1'b1;
              rx_char_q  <= rx_sh_q[7:1];
            end
          end else begin
            rx_sh_q  <= {~line_s2_q, rx_sh_q[8:1]};
            rx_bit_q <= rx_bit_q + 4'h1;
            rx_cnt_q <= 16'(BIT_CYCLES - 1);
          end
        end
        default: rx_q <= RX_IDLE;
      endcase
    end
  end

  // Command buffer; a fifth character before the terminator spoils the command
  assign cmd_hit = rx_valid_q && {1'b0, rx_char_q} == CH_BANG && ccnt_q != 3'd5;
  assign is_wild = cbuf_q[0] == CH_QUERY;
  assign addr_ok = cbuf_q[0] == addr_q;
  assign new_ok  = valid_addr(cbuf_q[2]);

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ccnt_q <= 3'd0;
      for (int i = 0; i < 4; i++) begin
        cbuf_q[i] <= 8'h00;
      end
    end else if (rx_valid_q) begin
      if ({1'b0, rx_char_q} == CH_BANG) begin
        ccnt_q <= 3'd0;
      end else if (ccnt_q < 3'd4) begin
        cbuf_q[ccnt_q[1:0]] <= {1'b0, rx_char_q};
        ccnt_q <= ccnt_q + 3'd1;
      end else begin
        ccnt_q <= 3'd5;
      end
    end
  end

  // Pending reply chosen from the finished command
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      reply_q <= MSG_NONE;
    end else if (cmd_hit) begin
      reply_q <= MSG_NONE;
      if (ccnt_q == 3'd1 && (addr_ok || is_wild)) begin
        reply_q <= MSG_ADDR;
      end
      // Change address needs the explicit address
      if (ccnt_q == 3'd3 && cbuf_q[1] == CH_CMD_A && addr_ok && new_ok) begin
        reply_q <= MSG_ADDR;
      end
      if (is_meas_cmd()) begin
        reply_q <= MSG_MEAS;
      end
      if (ccnt_q == 3'd3 && cbuf_q[1] == CH_CMD_D && cbuf_q[2] == CH_ZERO && (addr_ok || is_wild)) begin
        reply_q <= MSG_DATA;
      end
    end else if (msg_q == MSG_NONE && pwr_q == PWR_CMD && !tx_busy) begin
      reply_q <= MSG_NONE;
    end
  end

  // Field digits
  // Raw permittivity scaled by fifty
  assign raw_perm_bcd = bin2bcd(13'({6'h00, meas_q.dielectric} * {6'h00, PERM_SCALE}));
  assign raw_temp_bcd = bin2bcd({2'b00, meas_q.raw_temp});
  assign perm_bcd     = bin2bcd({6'h00, meas_q.dielectric});
  assign temp_mag     = meas_q.temp_c[7] ? 8'(-meas_q.temp_c) : meas_q.temp_c;
  assign temp_bcd     = bin2bcd({5'h00, temp_mag});
  assign time_bcd     = {4'h0, MEAS_TIME_S};

  // Character at the current position of the current message
  always_comb begin
    cur_char = CH_CR;
    cur_last = 1'b0;
    cur_skip = 1'b0;
    cur_sum  = 1'b0;
    unique case (msg_q)
      MSG_ADDR: begin
        unique case (idx_q)
          4'd0:    cur_char = addr_q;
          4'd1:    cur_char = CH_CR;
          default: begin
            cur_char = CH_LF;
            cur_last = 1'b1;
          end
        endcase
      end
      // Address, time in seconds, value count
      MSG_MEAS: begin
        unique case (idx_q)
          4'd0:    cur_char = addr_q;
          4'd1:    cur_char = digit(time_bcd[11:8]);
          4'd2:    cur_char = digit(time_bcd[7:4]);
          4'd3:    cur_char = digit(time_bcd[3:0]);
          4'd4:    cur_char = digit(VALUE_COUNT);
          4'd5:    cur_char = CH_CR;
          default: begin
            cur_char = CH_LF;
            cur_last = 1'b1;
          end
        endcase
      end
      MSG_DATA: begin
        unique case (idx_q)
          4'd0: cur_char = addr_q;
          4'd1: cur_char = CH_PLUS;
          4'd2: begin
            cur_char = digit(perm_bcd[11:8]);
            cur_skip = perm_bcd[11:8] == 4'h0;
          end
          4'd3: begin
            cur_char = digit(perm_bcd[7:4]);
            cur_skip = perm_bcd[11:4] == 8'h00;
          end
          4'd4: cur_char = digit(perm_bcd[3:0]);
          4'd5: cur_char = meas_q.temp_c[7] ? CH_MINUS : CH_PLUS;
          4'd6: begin
            cur_char = digit(temp_bcd[11:8]);
            cur_skip = temp_bcd[11:8] == 4'h0;
          end
          4'd7: begin
            cur_char = digit(temp_bcd[7:4]);
            cur_skip = temp_bcd[11:4] == 8'h00;
          end
          4'd8:    cur_char = digit(temp_bcd[3:0]);
          4'd9:    cur_char = CH_CR;
          default: begin
            cur_char = CH_LF;
            cur_last = 1'b1;
          end
        endcase
      end
      MSG_BURST: begin
        cur_sum = idx_q <= 4'd11;
        unique case (idx_q)
          4'd0:  cur_char = CH_TAB;
          4'd1:  cur_skip = raw_perm_bcd[15:12] == 4'h0;
          4'd2:  cur_skip = raw_perm_bcd[15:8] == 8'h00;
          4'd3:  cur_skip = raw_perm_bcd[15:4] == 12'h000;
          4'd6:  cur_skip = raw_temp_bcd[15:12] == 4'h0;
          4'd7:  cur_skip = raw_temp_bcd[15:8] == 8'h00;
          4'd8:  cur_skip = raw_temp_bcd[15:4] == 12'h000;
          4'd5:  cur_char = CH_SPACE;
          4'd10: cur_char = CH_CR;
          4'd11: cur_char = SENSOR_TYPE;
          default: begin
            cur_char = 8'h00;
          end
        endcase
        if (idx_q >= 4'd1 && idx_q <= 4'd4) begin
          cur_char = digit(raw_perm_bcd[4*(4-idx_q) +: 4]);
        end
        if (idx_q >= 4'd6 && idx_q <= 4'd9) begin
          cur_char = digit(raw_temp_bcd[4*(9-idx_q) +: 4]);
        end
        if (idx_q >= 4'd12) begin
          // Sum of all prior characters, mod 64, plus 32
          // No CRC6 character follows the checksum
          cur_char = {2'b00, sum_q} + {2'b00, CKSUM_OFFSET};
          cur_last = 1'b1;
        end
      end
      default: cur_char = CH_CR;
    endcase
  end

  // Message sequencer
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      msg_q       <= MSG_NONE;
      idx_q       <= 4'h0;
      sum_q       <= 6'h00;
      send_q      <= 1'b0;
      send_char_q <= 8'h00;
    end else begin
      send_q <= 1'b0;
      if (msg_q == MSG_NONE) begin
        idx_q <= 4'h0;
        sum_q <= 6'h00;
        if (pwr_q == PWR_HIGH && meas_done_in) begin
          msg_q <= MSG_BURST;
        end else if (pwr_q == PWR_CMD && !tx_busy && reply_q != MSG_NONE) begin
          msg_q <= reply_q;
        end else if (pwr_q == PWR_CMD && !tx_busy && srq_pend_q) begin
          msg_q <= MSG_ADDR;
        end
      end else if (cur_skip) begin
        idx_q <= idx_q + 4'h1;
      end else if (!tx_busy) begin
        send_q      <= 1'b1;
        send_char_q <= cur_char;
        idx_q       <= idx_q + 4'h1;
        if (cur_sum) begin
          sum_q <= sum_q + cur_char[5:0];
        end
        if (cur_last) begin
          msg_q <= MSG_NONE;
        end
      end
    end
  end

  // Burst frames true level; command frames inverted
  ssr_char_tx #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_tx (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n),
    .send_in     (send_q),
    .data_in     (send_char_q),
    .cmd_mode_in (pwr_q == PWR_CMD),
    .busy_out    (tx_busy),
    .pin_out     (tx_pin)
  );

  // Line drive: low for RAISE_CYCLES, high before burst, released when idle
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      line_q    <= 1'b0;
      line_oe_q <= 1'b1;
    end else begin
      unique case (pwr_q)
        PWR_STRAP, PWR_LOW: begin
          line_q    <= 1'b0;
          line_oe_q <= pwr_q == PWR_LOW;
        end
        PWR_HIGH: begin
          line_q    <= 1'b1;
          line_oe_q <= 1'b1;
        end
        PWR_BURST: begin
          line_q    <= (send_q || tx_busy) ? tx_pin : 1'b1;
          line_oe_q <= 1'b1;
        end
        PWR_CMD: begin
          line_q    <= tx_busy ? tx_pin : 1'b0;
          line_oe_q <= tx_busy;
        end
        default: begin
          line_q    <= 1'b0;
          line_oe_q <= 1'b0;
        end
      endcase
    end
  end

  assign line_out       = line_q;
  assign line_oe_out    = line_oe_q;
  assign meas_start_out = meas_start_q;
  assign addr_nv_out    = addr_q;
  assign addr_wr_out    = addr_wr_q;

endmodule // sensor_serial_responder

// *** verilog/ssr_char_tx.sv ***
// Purpose: One serial character out, ten bit times per frame
// Assumes: Caller waits for busy low before the next send
// Notes:   Command mode frames 7E1 inverted, burst mode frames 8N1 true level
module ssr_char_tx #(
  parameter int unsigned BIT_CYCLES = ssr_pkg::BIT_CYCLES_DFLT
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Character request
  input  wire logic       send_in,
  input  wire logic [7:0] data_in,
  input  wire logic       cmd_mode_in,
  output logic            busy_out,
  // Line level
  output logic            pin_out
);
  import ssr_pkg::*;

  logic [8:0]  shift_q;
  logic [15:0] cnt_q;
  logic [3:0]  nbit_q;
  logic        busy_q;
  logic        mode_q;
  logic        pin_q;
  logic [9:0]  frame;

  // Stop, parity or bit 7, seven data bits, start bit
  always_comb begin
    if (cmd_mode_in) begin
      frame = {1'b1, ^data_in[6:0], data_in[6:0], 1'b0};
    end else begin
      frame = {1'b1, data_in, 1'b0};
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shift_q <= 9'h000;
      cnt_q   <= 16'h0000;
      nbit_q  <= 4'h0;
      busy_q  <= 1'b0;
      mode_q  <= 1'b0;
      pin_q   <= 1'b1;
    end else if (!busy_q) begin
      if (send_in) begin
        busy_q  <= 1'b1;
        mode_q  <= cmd_mode_in;
        shift_q <= frame[9:1];
        nbit_q  <= 4'(FRAME_BITS - 1);
        cnt_q   <= 16'(BIT_CYCLES - 1);
        pin_q   <= cmd_mode_in ? ~frame[0] : frame[0];
      end
    end else if (cnt_q != 16'h0000) begin
      cnt_q <= cnt_q - 16'h0001;
    end else if (nbit_q == 4'h0) begin
      // Stop bit done: rest at the idle level of the frame's mode
      busy_q <= 1'b0;
      pin_q  <= ~mode_q;
    end else begin
      pin_q   <= mode_q ? ~shift_q[0] : shift_q[0];
      shift_q <= {1'b0, shift_q[8:1]};
      nbit_q  <= nbit_q - 4'h1;
      cnt_q   <= 16'(BIT_CYCLES - 1);
    end
  end

  // Send counts as busy at once so a caller never double-issues
  assign busy_out = busy_q | send_in;
  assign pin_out  = pin_q;

endmodule // ssr_char_tx

// *** verilog/ssr_pkg.sv ***
// Purpose: Shared constants and types for the sensor serial responder
// Assumes: 50 MHz system clock, one serial data line shared by both protocols
// Notes:   Character codes are eight bits; command mode uses only the low seven
package ssr_pkg;

  // Clock and line timing
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned BAUD_RATE       = 1200;
  localparam int unsigned BIT_CYCLES_DFLT = (CLK_HZ + BAUD_RATE - 1) / BAUD_RATE;
  localparam int unsigned RAISE_MAX_MS    = 100;
  // Half the allowed window, so the line is surely high in time
  localparam int unsigned RAISE_TIME_MS   = RAISE_MAX_MS / 2;
  localparam int unsigned RAISE_CYCLES    = (CLK_HZ / 1000) * RAISE_TIME_MS;
  localparam int unsigned FRAME_BITS      = 10;

  // Measurement answer fields
  localparam logic [11:0] MEAS_TIME_S     = 12'h001;
  localparam logic [3:0]  VALUE_COUNT     = 4'h2;
  localparam logic [6:0]  PERM_SCALE      = 7'd50;
  localparam logic [5:0]  CKSUM_OFFSET    = 6'h20;

  // Character codes
  localparam logic [7:0] CH_TAB   = 8'h09;
  localparam logic [7:0] CH_LF    = 8'h0a;
  localparam logic [7:0] CH_CR    = 8'h0d;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_PLUS  = 8'h2b;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_BANG  = 8'h21;
  localparam logic [7:0] CH_QUERY = 8'h3f;
  localparam logic [7:0] CH_CMD_A = 8'h41;
  localparam logic [7:0] CH_CMD_D = 8'h44;
  localparam logic [7:0] CH_CMD_M = 8'h4d;
  localparam logic [7:0] ADDR_FACTORY = 8'h30;

  // Measurement result handed over by the analog front end
  typedef struct packed {
    logic [6:0]  dielectric;
    logic [7:0]  temp_c;
    logic [10:0] raw_temp;
  } ssr_meas_t;

  typedef enum logic [2:0] {
    PWR_STRAP = 3'b000,
    PWR_LOW   = 3'b001,
    PWR_HIGH  = 3'b010,
    PWR_BURST = 3'b011,
    PWR_CMD   = 3'b100
  } ssr_pwr_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_BITS  = 2'b10
  } ssr_rx_t;

  typedef enum logic [2:0] {
    MSG_NONE  = 3'b000,
    MSG_ADDR  = 3'b001,
    MSG_MEAS  = 3'b010,
    MSG_DATA  = 3'b011,
    MSG_BURST = 3'b100
  } ssr_msg_t;

endpackage : ssr_pkg
